/* File: hdl/asb_regs.svh */
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 32-bit APB data, one register per aligned word
// Notes: buffer RAM is one byte per word from ASB_OFF_RAM upward
`ifndef ASB_REGS_SVH
`define ASB_REGS_SVH
`define ASB_OFF_MODE 8'h00
`define ASB_OFF_CTRL 8'h04
`define ASB_OFF_PTR 8'h08
`define ASB_OFF_SHIFT 8'h0C
`define ASB_OFF_INTV 8'h10
`define ASB_OFF_STAT 8'h14
`define ASB_OFF_HALT 8'h18
`define ASB_OFF_RAM 8'h40
`define ASB_RAM_DEPTH 32
`define ASB_RAM_AW 5
`define ASB_BIT_ENABLE 7
`define ASB_BIT_ATE 5
`define ASB_BIT_POL 0
`define ASB_BIT_WAIT 1
`define ASB_BIT_TRF 3
`define ASB_BIT_AUTO_RELOAD_SELECT 5
`define ASB_BIT_RE 6
`define ASB_BIT_INTV_EN 7
`define ASB_BIT_IRQ 0
`define ASB_RESET_WORD 32'h0000_0000
`define ASB_CLK_NS 8
`define ASB_SCK_NS 64
`define ASB_HALF_CYC ((`ASB_SCK_NS / 2) / `ASB_CLK_NS)
`define ASB_GAP_HALVES 7'h04
`endif

/* File: hdl/asb_pkg.sv */
// Purpose: transfer state type, used by the master only
// Assumes: nothing
// Notes: state codes are fixed binary
package asb_pkg;
  typedef enum logic [2:0] {
    ASB_IDLE = 3'b000,
    ASB_LOAD = 3'b001,
    ASB_SHIFT = 3'b010,
    ASB_GAP = 3'b011,
    ASB_WAIT = 3'b100
  } asb_state_t;
endpackage

/* File: hdl/asb_link_if.sv */
// Purpose: pins between transfer master and serial slave
// Assumes: bench resolves levels from the enables
// Notes: no clocking block
`timescale 1ns/1ps
interface asb_link_if;
  logic sck;
  logic sck_oe;
  logic so;
  logic so_oe;
  logic si_en;
  logic stb;
  logic stb_oe;
  logic busy_en;
  logic busy;
  modport master (output sck, output sck_oe, output so, output so_oe, output si_en,
                  output stb, output stb_oe, output busy_en, input busy);
  modport slave (input sck, input sck_oe, input so, input so_oe, input si_en,
                 input stb, input stb_oe, input busy_en, output busy);
endinterface

/* File: hdl/asb_master.sv */
// Purpose: automatic buffer-to-serial transmit engine with APB registers
// Assumes: internal serial clock, transmit only, busy from the slave is asynchronous
// Notes: serial clock idles high, data changes on its falling edge
// Contract
// - Shift-register write starts transfer while enabled
// - Final byte sets flag; software polls progress
// - Unused input, strobe, busy pins stay ports
// - Fetch next byte after a gap
// - Serial output low while not transferring
// - Load byte, decrement pointer, load next
// - Auto-reload sends buffer cyclically forever
// - Repeat wraps pointer, no flag set
// - Disable suspends after current byte completes
// - Suspend clears progress, pins to port
// - Restart continues from preserved pointer
// - Halt freezes transfer mid-byte, resumes exactly
// - Software avoids mode change while transferring
// - Busy wait needs both enable bits
// - Busy ignored while a byte shifts
// - Busy two clocks after byte stalls
// - Polarity bit: zero high, one low
// - Software uses internal clock with busy
// - Interval control overrides busy handshake
// - Software loads pointer with count minus one
// - Sequence ends after lowest address byte
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "asb_regs.svh"
module asb_master (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  asb_link_if.master link
);
  logic [7:0] mode_r;
  logic [7:0] ctrl_r;
  logic [7:0] intv_r;
  logic halt_r;
  logic [`ASB_RAM_AW-1:0] ptr_r;
  logic [`ASB_RAM_AW-1:0] start_ptr_r;
  logic [7:0] ram [0:`ASB_RAM_DEPTH-1];
  logic [7:0] shreg_r;
  logic [2:0] bits_r;
  logic [2:0] hcnt_r;
  logic [6:0] gap_r;
  logic trf_r;
  logic irq_r;
  logic sck_r;
  logic so_r;
  logic busy_s1_r;
  logic busy_s2_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic sck_oe_r;
  logic so_oe_r;
  logic si_en_r;
  logic busy_en_r;
  asb_pkg::asb_state_t state_r;

  function automatic logic is_ram(input logic [7:0] a);
    is_ram = a >= `ASB_OFF_RAM && a < `ASB_OFF_RAM + 8'(4 * `ASB_RAM_DEPTH) && a[1:0] == 2'b00;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = is_ram(a) || a == `ASB_OFF_MODE || a == `ASB_OFF_CTRL || a == `ASB_OFF_PTR ||
             a == `ASB_OFF_SHIFT || a == `ASB_OFF_INTV || a == `ASB_OFF_STAT || a == `ASB_OFF_HALT;
  endfunction
  function automatic logic [`ASB_RAM_AW-1:0] ram_idx(input logic [7:0] a);
    ram_idx = 5'((a - `ASB_OFF_RAM) >> 2);
  endfunction

  logic acc;
  logic wr;
  logic enable;
  logic tick;
  logic busy_act;
  logic busy_ok;
  logic byte_done;
  assign acc = psel && penable && pready_r;
  assign wr = acc && pwrite;
  assign enable = mode_r[`ASB_BIT_ENABLE];
  assign tick = hcnt_r == 3'(`ASB_HALF_CYC - 1);
  assign busy_act = busy_s2_r ^ ctrl_r[`ASB_BIT_POL];
  // Interval spacing wins over the handshake
  assign busy_ok = mode_r[`ASB_BIT_ATE] && ctrl_r[`ASB_BIT_WAIT] && !intv_r[`ASB_BIT_INTV_EN];
  assign byte_done = state_r == asb_pkg::ASB_SHIFT && tick && !sck_r && bits_r == 3'h7;

  // APB slave: one wait state so read data comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= `ASB_RESET_WORD;
    end else begin
      pready_r <= psel && penable && !pready_r;
      pslverr_r <= psel && penable && !pready_r && !mapped(paddr);
      prdata_r <= `ASB_RESET_WORD;
      if (psel && penable && !pready_r && !pwrite) begin
        if (is_ram(paddr)) begin
          prdata_r <= {24'h0, ram[ram_idx(paddr)]};
        end else begin
          unique case (paddr)
            `ASB_OFF_MODE: prdata_r <= {24'h0, mode_r};
            `ASB_OFF_CTRL: prdata_r <= {24'h0, ctrl_r[7:4], trf_r, ctrl_r[2:0]};
            `ASB_OFF_PTR: prdata_r <= {27'h0, ptr_r};
            `ASB_OFF_SHIFT: prdata_r <= {24'h0, shreg_r};
            `ASB_OFF_INTV: prdata_r <= {24'h0, intv_r};
            `ASB_OFF_STAT: prdata_r <= {31'h0, irq_r};
            `ASB_OFF_HALT: prdata_r <= {31'h0, halt_r};
            default: prdata_r <= `ASB_RESET_WORD;
          endcase
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= 8'h00;
      ctrl_r <= 8'h00;
      intv_r <= 8'h00;
      halt_r <= 1'b0;
    end else if (wr) begin
      if (paddr == `ASB_OFF_MODE) mode_r <= pwdata[7:0];
      if (paddr == `ASB_OFF_CTRL) ctrl_r <= {pwdata[7:4], 1'b0, pwdata[2:0]};
      if (paddr == `ASB_OFF_INTV) intv_r <= pwdata[7:0];
      if (paddr == `ASB_OFF_HALT) halt_r <= pwdata[0];
    end
  end

  // Buffer contents need no reset
  always_ff @(posedge pclk) begin
    if (wr && is_ram(paddr)) begin
      ram[ram_idx(paddr)] <= pwdata[7:0];
    end
  end

  // Busy is asynchronous to pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_s1_r <= 1'b0;
      busy_s2_r <= 1'b0;
    end else begin
      busy_s1_r <= link.busy;
      busy_s2_r <= busy_s1_r;
    end
  end

  // Transfer engine; halt freezes every counter in place while the transfer flag is set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= asb_pkg::ASB_IDLE;
      ptr_r <= '0;
      start_ptr_r <= '0;
      shreg_r <= 8'h00;
      bits_r <= 3'h0;
      hcnt_r <= 3'h0;
      gap_r <= 7'h00;
      trf_r <= 1'b0;
      irq_r <= 1'b0;
      sck_r <= 1'b1;
      so_r <= 1'b0;
    end else begin
      // Flag set by a completing byte beats the software clear
      if (wr && paddr == `ASB_OFF_STAT && pwdata[`ASB_BIT_IRQ]) irq_r <= 1'b0;
      if (wr && paddr == `ASB_OFF_PTR) begin
        ptr_r <= pwdata[`ASB_RAM_AW-1:0];
        start_ptr_r <= pwdata[`ASB_RAM_AW-1:0];
      end
      if (!(halt_r && trf_r)) begin
        hcnt_r <= tick ? 3'h0 : hcnt_r + 3'h1;
        unique case (state_r)
          asb_pkg::ASB_IDLE: begin
            so_r <= 1'b0;
            sck_r <= 1'b1;
            if (wr && paddr == `ASB_OFF_SHIFT && enable) begin
              trf_r <= 1'b1;
              state_r <= asb_pkg::ASB_LOAD;
            end
          end
          asb_pkg::ASB_LOAD: begin
            if (!enable) begin
              trf_r <= 1'b0;
              so_r <= 1'b0;
              state_r <= asb_pkg::ASB_IDLE;
            end else begin
              shreg_r <= ram[ptr_r];
              bits_r <= 3'h0;
              hcnt_r <= 3'h0;
              state_r <= asb_pkg::ASB_SHIFT;
            end
          end
          asb_pkg::ASB_SHIFT: begin
            if (tick) begin
              sck_r <= !sck_r;
              if (sck_r) begin
                so_r <= shreg_r[7];
                shreg_r <= {shreg_r[6:0], 1'b0};
              end else begin
                bits_r <= bits_r + 3'h1;
              end
            end
            if (byte_done) begin
              gap_r <= intv_r[`ASB_BIT_INTV_EN] ? {1'b0, intv_r[4:0], 1'b0} + 7'h02 : `ASB_GAP_HALVES;
              state_r <= asb_pkg::ASB_GAP;
              if (ptr_r != '0) begin
                ptr_r <= ptr_r - 1'b1;
              end else if (ctrl_r[`ASB_BIT_AUTO_RELOAD_SELECT] && !ctrl_r[`ASB_BIT_RE]) begin
                ptr_r <= start_ptr_r;
              end else begin
                irq_r <= 1'b1;
                trf_r <= 1'b0;
                so_r <= 1'b0;
                state_r <= asb_pkg::ASB_IDLE;
              end
              if (!enable) begin
                trf_r <= 1'b0;
                so_r <= 1'b0;
                state_r <= asb_pkg::ASB_IDLE;
              end
            end
          end
          asb_pkg::ASB_GAP: begin
            if (tick) begin
              gap_r <= gap_r - 7'h01;
              if (gap_r == 7'h01) begin
                // Busy only counts once the byte and the gap are over
                state_r <= (busy_ok && busy_act) ? asb_pkg::ASB_WAIT : asb_pkg::ASB_LOAD;
              end
            end
          end
          asb_pkg::ASB_WAIT: begin
            if (tick && !(busy_ok && busy_act)) state_r <= asb_pkg::ASB_LOAD;
          end
          default: state_r <= asb_pkg::ASB_IDLE;
        endcase
      end
    end
  end

  // Pin functions follow the transfer flag one cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_oe_r <= 1'b0;
      so_oe_r <= 1'b0;
      si_en_r <= 1'b0;
      busy_en_r <= 1'b0;
    end else begin
      sck_oe_r <= trf_r;
      so_oe_r <= trf_r;
      si_en_r <= trf_r && ctrl_r[`ASB_BIT_RE];
      busy_en_r <= trf_r && busy_ok;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign link.sck = sck_r;
  assign link.sck_oe = sck_oe_r;
  assign link.so = so_r;
  assign link.so_oe = so_oe_r;
  assign link.si_en = si_en_r;
  assign link.stb = 1'b0;
  assign link.stb_oe = 1'b0;
  assign link.busy_en = busy_en_r;
endmodule

/* File: hdl/asb_slave.sv */
// Purpose: serial slave that receives bytes and drives busy
// Assumes: serial clock and data arrive from another domain
// Notes: byte framing resets whenever the master releases the clock pin
`timescale 1ns/1ps
module asb_slave (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic busy_req,
  input wire logic busy_low,
  output logic [7:0] rx_data,
  output logic rx_valid,
  asb_link_if.slave link
);
  logic [2:0] sck_s_r;
  logic [1:0] so_s_r;
  logic [1:0] oe_s_r;
  logic [7:0] sh_r;
  logic [2:0] cnt_r;
  logic [7:0] rx_data_r;
  logic rx_valid_r;
  logic busy_r;

  // sck_s_r[0] and so_s_r[0] are synchroniser first stages only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_s_r <= 3'h7;
      so_s_r <= 2'h0;
      oe_s_r <= 2'h0;
    end else begin
      sck_s_r <= {sck_s_r[1:0], link.sck};
      so_s_r <= {so_s_r[0], link.so};
      oe_s_r <= {oe_s_r[0], link.sck_oe};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_r <= 8'h00;
      cnt_r <= 3'h0;
      rx_data_r <= 8'h00;
      rx_valid_r <= 1'b0;
    end else begin
      rx_valid_r <= 1'b0;
      if (!oe_s_r[1]) begin
        cnt_r <= 3'h0;
      end else if (sck_s_r[1] && !sck_s_r[2]) begin
        sh_r <= {sh_r[6:0], so_s_r[1]};
        cnt_r <= cnt_r + 3'h1;
        if (cnt_r == 3'h7) begin
          rx_data_r <= {sh_r[6:0], so_s_r[1]};
          rx_valid_r <= 1'b1;
        end
      end
    end
  end

  // Polarity matches the master's select: low when busy_low set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= busy_req ^ busy_low;
    end
  end

  assign rx_data = rx_data_r;
  assign rx_valid = rx_valid_r;
  assign link.busy = busy_r;
endmodule

/* File: testbench/asb_link_sva.sv */
// Purpose: link pin checks between both ends
// Assumes: pin enables lag progress by one clock
// Notes: halt may stretch a low half, never shorten it
`timescale 1ns/1ps
module asb_link_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sck,
  input wire logic sck_oe,
  input wire logic so,
  input wire logic so_oe,
  input wire logic si_en,
  input wire logic stb,
  input wire logic stb_oe,
  input wire logic busy_en,
  input wire logic busy
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence low_half;
    !sck [*4];
  endsequence
  sequence byte_end;
    sck && $past(sck);
  endsequence
  strobe_off_a: assert property (!stb && !stb_oe) else $error("strobe pin driven");
  input_off_a: assert property (!si_en) else $error("serial input taken");
  so_idle_low_a: assert property (!so_oe |-> !so) else $error("data high while idle");
  sck_idle_a: assert property (!sck_oe |-> sck) else $error("clock low while idle");
  oe_pair_a: assert property (so_oe == sck_oe) else $error("pin enables split");
  sck_half_a: assert property ($fell(sck) |-> low_half) else $error("clock low half short");
  so_edge_a: assert property (sck_oe && $past(sck_oe) && $changed(so) |-> $fell(sck) || !so)
    else $error("data moved off clock fall");
  busy_gate_a: assert property (busy_en |-> sck_oe) else $error("busy gate outside transfer");
  stop_whole_a: assert property ($fell(sck_oe) |-> byte_end) else $error("stopped mid byte");
  busy_seen_c: cover property (busy_en && busy);
endmodule

/* File: testbench/auto_serial_buffer_transfer_tb.sv */
// Purpose: drives both ends over APB and slave controls
// Assumes: buffer byte i holds A0 plus i
// Notes: expected order is pointer value downward
`timescale 1ns/1ps
`include "asb_regs.svh"
module auto_serial_buffer_transfer_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, busy_req, busy_low, rx_valid, e, s;
  logic [7:0] paddr, rx_data;
  logic [31:0] pwdata, prdata, rd;
  int fails, cmp_count;
  logic [7:0] rxq[$];
  asb_link_if lk();
  asb_master u_asb_master(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(lk.master));
  asb_slave u_asb_slave(.pclk(pclk), .presetn(presetn), .busy_req(busy_req), .busy_low(busy_low),
    .rx_data(rx_data), .rx_valid(rx_valid), .link(lk.slave));
  asb_link_sva u_asb_link_sva(.pclk(pclk), .presetn(presetn), .sck(lk.sck), .sck_oe(lk.sck_oe), .so(lk.so),
    .so_oe(lk.so_oe), .si_en(lk.si_en), .stb(lk.stb), .stb_oe(lk.stb_oe), .busy_en(lk.busy_en), .busy(lk.busy));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) if (rx_valid === 1'b1) rxq.push_back(rx_data);
  task give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x) begin
      fails++;
      $display("CHECK FAILED %s exp %h seen %h", n, x, g);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      fails++;
      give_verdict();
    end
  endtask
  task wait_idle;
    int n;
    n = 0;
    do begin
      apb(1'b0, `ASB_OFF_CTRL, 32'h0);
      n++;
    end while (rd[3] !== 1'b0 && n < 1000);
    if (n >= 1000) begin
      fails++;
      give_verdict();
    end
  endtask
  task wait_rx(input int k);
    int n;
    n = 0;
    while (rxq.size() < k && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 5000) begin
      fails++;
      give_verdict();
    end
  endtask
  task chk_seq(input string n, input int p, input int k);
    chk(n, 32'(rxq.size()), 32'(k));
    for (int j = 0; j < k && j < rxq.size(); j++) chk(n, 32'(rxq[j]), 32'(8'hA0 + p - j % (p + 1)));
  endtask
  task start(input int p);
    rxq.delete();
    apb(1'b1, `ASB_OFF_PTR, 32'(p));
    apb(1'b1, `ASB_OFF_SHIFT, 32'h5A);
  endtask
  task t_basic;
    apb(1'b0, `ASB_OFF_MODE, 32'h0);
    chk("mode reset", rd, `ASB_RESET_WORD);
    apb(1'b0, 8'hFC, 32'h0);
    chk("unmapped", {rd[30:0], e}, 32'h1);
    apb(1'b0, 8'(`ASB_OFF_RAM + 4 * 31), 32'h0);
    chk("ram top", rd, 32'hBF);
    start(5);
    apb(1'b0, `ASB_OFF_CTRL, 32'h0);
    chk("start disabled", 32'(rd[3]), 32'h0);
    apb(1'b1, `ASB_OFF_MODE, 32'h80);
    apb(1'b1, `ASB_OFF_SHIFT, 32'h5A);
    apb(1'b0, `ASB_OFF_CTRL, 32'h0);
    chk("start enabled", 32'(rd[3]), 32'h1);
    wait_idle();
    wait_rx(6);
    chk_seq("basic order", 5, 6);
    apb(1'b0, `ASB_OFF_STAT, 32'h0);
    chk("done set", 32'(rd[0]), 32'h1);
    apb(1'b1, `ASB_OFF_STAT, 32'h1);
    apb(1'b0, `ASB_OFF_STAT, 32'h0);
    chk("done clear", 32'(rd[0]), 32'h0);
    $display("basic test ended");
  endtask
  task t_suspend;
    start(5);
    wait_rx(2);
    apb(1'b1, `ASB_OFF_MODE, 32'h0);
    wait_idle();
    chk("suspend count", 32'(rxq.size()), 32'h2);
    apb(1'b0, `ASB_OFF_PTR, 32'h0);
    chk("kept pointer", rd, 32'h3);
    apb(1'b1, `ASB_OFF_MODE, 32'h80);
    apb(1'b1, `ASB_OFF_SHIFT, 32'h5A);
    wait_idle();
    wait_rx(6);
    chk_seq("resume order", 5, 6);
    $display("suspend test ended");
  endtask
  task t_halt;
    start(2);
    repeat (30) @(posedge pclk);
    apb(1'b1, `ASB_OFF_HALT, 32'h1);
    @(posedge pclk);
    s = lk.sck;
    repeat (50) @(posedge pclk);
    chk("clock frozen", 32'(lk.sck), 32'(s));
    apb(1'b0, `ASB_OFF_CTRL, 32'h0);
    chk("halt keeps flag", 32'(rd[3]), 32'h1);
    apb(1'b1, `ASB_OFF_HALT, 32'h0);
    wait_idle();
    wait_rx(3);
    chk_seq("halt order", 2, 3);
    apb(1'b1, `ASB_OFF_STAT, 32'h1);
    $display("halt test ended");
  endtask
  task t_repeat;
    apb(1'b1, `ASB_OFF_CTRL, 32'h20);
    start(2);
    wait_rx(7);
    chk_seq("repeat order", 2, 7);
    apb(1'b0, `ASB_OFF_STAT, 32'h0);
    chk("repeat no done", 32'(rd[0]), 32'h0);
    apb(1'b1, `ASB_OFF_MODE, 32'h0);
    wait_idle();
    apb(1'b1, `ASB_OFF_CTRL, 32'h0);
    $display("repeat test ended");
  endtask
  task t_busy;
    for (int m = 0; m < 3; m++) begin
      busy_low <= (m == 1);
      busy_req <= 1'b1;
      apb(1'b1, `ASB_OFF_CTRL, 32'h2 + 32'(m == 1));
      apb(1'b1, `ASB_OFF_INTV, (m == 2) ? 32'h80 : 32'h0);
      apb(1'b1, `ASB_OFF_MODE, 32'hA0);
      start(1);
      wait_rx(1);
      repeat (200) @(posedge pclk);
      chk("busy stall", 32'(rxq.size()), (m == 2) ? 32'h2 : 32'h1);
      busy_req <= 1'b0;
      wait_idle();
      wait_rx(2);
      chk_seq("busy order", 1, 2);
    end
    $display("busy test ended");
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    busy_req = 1'b0;
    busy_low = 1'b0;
    fails = 0;
    cmp_count = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < `ASB_RAM_DEPTH; i++) apb(1'b1, 8'(`ASB_OFF_RAM + 4 * i), 32'(8'hA0 + i));
    t_basic();
    t_suspend();
    t_halt();
    t_repeat();
    t_busy();
    give_verdict();
  end
endmodule
